// ===== include/clock_select_pkg.sv
package clock_select_pkg;
   localparam logic [4:0] CLK_CTRL_OFF    = 5'h00;
   localparam logic [4:0] CLK_CFG_OFF     = 5'h04;
   localparam logic [4:0] BACKUP_CTRL_OFF = 5'h08;
   localparam logic [4:0] RTC_COUNT_OFF   = 5'h0c;
   localparam logic [4:0] CLK_STATUS_OFF  = 5'h10;

   localparam int FAST_EN_BIT     = 0;
   localparam int FAST_BYPASS_BIT = 1;
   localparam int PLL_REF_LSB     = 2;
   localparam int CKOUT_SEL_LSB   = 0;
   localparam int SLOW_EN_BIT     = 0;
   localparam int SLOW_BYPASS_BIT = 1;
   localparam int SLOW_DRIVE_LSB  = 2;
   localparam int RTC_SRC_BIT     = 4;
   localparam int RTC_EN_BIT      = 5;
   localparam int ST_RUN_BIT      = 0;
   localparam int ST_PWR_BIT      = 1;

   localparam logic [3:0]  CLK_CTRL_RST    = 4'h0;
   localparam logic [2:0]  CLK_CFG_RST     = 3'h0;
   localparam logic [5:0]  BACKUP_CTRL_RST = 6'h00;
   localparam logic [31:0] RTC_COUNT_RST   = 32'h0000_0000;

   localparam int NUM_SRC = 8;

   typedef enum logic [2:0] {
      CKOUT_SYS, CKOUT_RC8M, CKOUT_FAST, CKOUT_PLL_HALF,
      CKOUT_PLL2_HALF, CKOUT_SLOW, CKOUT_RC48M, CKOUT_RSVD
   } clkout_sel_t;

   typedef enum logic [1:0] {
      PLLREF_FAST, PLLREF_RC8M, PLLREF_RC48M, PLLREF_RSVD
   } pll_ref_t;

   typedef enum logic [1:0] {
      DRIVE_LOW, DRIVE_MED_LOW, DRIVE_MED_HIGH, DRIVE_HIGH
   } slow_drive_t;
endpackage

// ===== hw/clock_edge_sampler.sv
`timescale 1ns/1ps
module clock_edge_sampler #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] srcLevel,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] level_ff;
   logic [WIDTH-1:0] prev_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_src
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               level_ff[i] <= 1'b0;
               prev_ff[i]  <= 1'b0;
            end else begin
               level_ff[i] <= srcLevel[i];
               prev_ff[i]  <= level_ff[i];
            end
         end
         assign rise[i] = level_ff[i] & ~prev_ff[i];
      end
   endgenerate

   assign level = level_ff;
endmodule // clock_edge_sampler

// ===== hw/clock_source_output_select.sv
`timescale 1ns/1ps
// Function
// - Three-bit select routes one of seven clocks to the clock output.
// - Fast bypass bit takes external clock on input pin, amplifier off.
// - Slow bypass bit takes external 32.768 kHz clock, amplifier off.
// - Main PLL reference chosen from fast oscillator, 8 MHz or 48 MHz RC.
// - Software sets slow oscillator drive strength, including a high-drive option.
// - Counter on 40 kHz RC halts without main power, resumes retained value.
module clock_source_output_select
   import clock_select_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        systemClock,
   input  wire logic        internalRc8m,
   input  wire logic        internalRc48m,
   input  wire logic        internalRc40k,
   input  wire logic        mainPllClock,
   input  wire logic        secondPllClock,
   input  wire logic        fastOscInputPin,
   input  wire logic        fastOscAmpClock,
   input  wire logic        slowOscInputPin,
   input  wire logic        slowOscAmpClock,
   input  wire logic        mainPowerGood,
   output logic             fastOscAmpEnable,
   output logic             slowOscAmpEnable,
   output logic [1:0]       slowOscDrive,
   output logic             mainPllRef,
   output logic             clkOut,
   output logic [31:0]      rtcCount
);
   logic [3:0]         clkCtrl_ff;
   logic [2:0]         clkCfg_ff;
   logic [5:0]         backupCtrl_ff;
   logic [31:0]        rtcCount_ff;
   logic               pllHalf_ff;
   logic               pll2Half_ff;
   logic               clkOut_ff;
   logic               pllRef_ff;
   logic [31:0]        prdata_ff;
   logic               fastOscClk;
   logic               slowOscClk;
   logic [NUM_SRC-1:0] rawSrc;
   logic [NUM_SRC-1:0] srcLevel;
   logic [NUM_SRC-1:0] srcRise;
   logic               accessPhase;
   logic               wrEn;
   logic               mapped;
   logic [4:0]         regAddr;
   logic               rtcFromRc40k;
   logic               rtcRunning;
   logic               rtcTick;
   logic               nxt_clkOut;
   logic               nxt_pllRef;
   clkout_sel_t        outSel;
   pll_ref_t           refSel;

   // Zero-wait slave: every access completes in its first access cycle
   assign accessPhase = psel & penable;
   assign regAddr     = paddr[4:0];
   assign mapped      = (paddr[31:5] == 27'h0) &&
                        (regAddr == CLK_CTRL_OFF || regAddr == CLK_CFG_OFF ||
                         regAddr == BACKUP_CTRL_OFF || regAddr == RTC_COUNT_OFF ||
                         regAddr == CLK_STATUS_OFF);
   assign wrEn        = accessPhase & pwrite & mapped;
   assign pready      = 1'b1;
   assign pslverr     = accessPhase & ~mapped;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clkCtrl_ff    <= CLK_CTRL_RST;
         clkCfg_ff     <= CLK_CFG_RST;
         backupCtrl_ff <= BACKUP_CTRL_RST;
      end else if (wrEn) begin
         unique case (regAddr)
            CLK_CTRL_OFF:    clkCtrl_ff    <= pwdata[3:0];
            CLK_CFG_OFF:     clkCfg_ff     <= pwdata[2:0];
            BACKUP_CTRL_OFF: backupCtrl_ff <= pwdata[5:0];
            default: ;
         endcase
      end
   end

   // Read data registered at the end of the setup phase, stable until the next read
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata_ff <= 32'h0000_0000;
         unique case (regAddr)
            CLK_CTRL_OFF:    prdata_ff[3:0] <= clkCtrl_ff;
            CLK_CFG_OFF:     prdata_ff[2:0] <= clkCfg_ff;
            BACKUP_CTRL_OFF: prdata_ff[5:0] <= backupCtrl_ff;
            RTC_COUNT_OFF:   prdata_ff      <= rtcCount_ff;
            CLK_STATUS_OFF: begin
               prdata_ff[ST_RUN_BIT] <= rtcRunning;
               prdata_ff[ST_PWR_BIT] <= mainPowerGood;
            end
            default: ;
         endcase
      end
   end
   assign prdata = prdata_ff;

   // Oscillator front ends: bypass turns off the amplifier and uses the pin
   assign fastOscAmpEnable = clkCtrl_ff[FAST_EN_BIT] & ~clkCtrl_ff[FAST_BYPASS_BIT];
   assign fastOscClk       = clkCtrl_ff[FAST_BYPASS_BIT] ? fastOscInputPin
                                                         : fastOscAmpClock;
   assign slowOscAmpEnable = backupCtrl_ff[SLOW_EN_BIT] &
                             ~backupCtrl_ff[SLOW_BYPASS_BIT];
   assign slowOscClk       = backupCtrl_ff[SLOW_BYPASS_BIT] ? slowOscInputPin
                                                            : slowOscAmpClock;
   assign slowOscDrive     = backupCtrl_ff[SLOW_DRIVE_LSB +: 2];

   assign rawSrc = {internalRc40k, internalRc48m, slowOscClk, secondPllClock,
                    mainPllClock, fastOscClk, internalRc8m, systemClock};

   // Sources are sampled, so only those well below half the system rate
   // survive intact; faster ones alias on the output
   clock_edge_sampler #(
      .WIDTH (NUM_SRC)
   ) u_sampler (
      .clock    (clock),
      .arst_n   (arst_n),
      .srcLevel (rawSrc),
      .level    (srcLevel),
      .rise     (srcRise)
   );

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pllHalf_ff  <= 1'b0;
         pll2Half_ff <= 1'b0;
      end else begin
         if (srcRise[3]) begin
            pllHalf_ff <= ~pllHalf_ff;
         end
         if (srcRise[4]) begin
            pll2Half_ff <= ~pll2Half_ff;
         end
      end
   end

   assign outSel = clkout_sel_t'(clkCfg_ff);
   always_comb begin
      unique case (outSel)
         CKOUT_SYS:       nxt_clkOut = srcLevel[0];
         CKOUT_RC8M:      nxt_clkOut = srcLevel[1];
         CKOUT_FAST:      nxt_clkOut = srcLevel[2];
         CKOUT_PLL_HALF:  nxt_clkOut = pllHalf_ff;
         CKOUT_PLL2_HALF: nxt_clkOut = pll2Half_ff;
         CKOUT_SLOW:      nxt_clkOut = srcLevel[5];
         CKOUT_RC48M:     nxt_clkOut = srcLevel[6];
         CKOUT_RSVD:      nxt_clkOut = 1'b0;
      endcase
   end

   assign refSel = pll_ref_t'(clkCtrl_ff[PLL_REF_LSB +: 2]);
   always_comb begin
      unique case (refSel)
         PLLREF_FAST:  nxt_pllRef = srcLevel[2];
         PLLREF_RC8M:  nxt_pllRef = srcLevel[1];
         PLLREF_RC48M: nxt_pllRef = srcLevel[6];
         PLLREF_RSVD:  nxt_pllRef = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clkOut_ff <= 1'b0;
         pllRef_ff <= 1'b0;
      end else begin
         clkOut_ff <= nxt_clkOut;
         pllRef_ff <= nxt_pllRef;
      end
   end
   assign clkOut     = clkOut_ff;
   assign mainPllRef = pllRef_ff;

   // Counter source: slow external oscillator keeps running on battery,
   // the 40 kHz RC lives in the main domain and stops with it
   assign rtcFromRc40k = backupCtrl_ff[RTC_SRC_BIT];
   assign rtcRunning   = backupCtrl_ff[RTC_EN_BIT] &
                         (~rtcFromRc40k | mainPowerGood);
   assign rtcTick      = rtcRunning & (rtcFromRc40k ? srcRise[7] : srcRise[5]);

   // Power loss only pauses; the value is kept, never cleared
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rtcCount_ff <= RTC_COUNT_RST;
      end else if (wrEn && regAddr == RTC_COUNT_OFF) begin
         rtcCount_ff <= pwdata;
      end else if (rtcTick) begin
         rtcCount_ff <= rtcCount_ff + 32'h0000_0001;
      end
   end
   assign rtcCount = rtcCount_ff;
endmodule // clock_source_output_select

// ===== testbench/clock_sources_model.sv
`timescale 1ns/1ps
module clock_sources_model (
   input  wire logic       clock,
   input  wire logic       fastAmpEn,
   input  wire logic       slowAmpEn,
   output logic      [9:0] srcClk
);
   logic [9:0] cnt = 10'h0;
   always @(posedge clock) cnt <= cnt + 10'h1;
   // Counter bits at 10 MHz or slower, so the sampled paths never alias
   // A stopped amplifier gives no clock at all
   // The output pin is taken as already set to its alternate function
   assign srcClk = {cnt[2] & slowAmpEn, cnt[6], cnt[3] & fastAmpEn, cnt[5], cnt[4],
                    cnt[3], cnt[2], cnt[4], cnt[2], cnt[1]};
endmodule // clock_sources_model

// ===== testbench/clock_select_asserts.sv
`timescale 1ns/1ps
module clock_select_asserts
   import clock_select_pkg::*;
(
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        systemClock,
   input wire logic        internalRc8m,
   input wire logic        internalRc48m,
   input wire logic        mainPowerGood,
   input wire logic        fastOscAmpEnable,
   input wire logic        slowOscAmpEnable,
   input wire logic [1:0]  slowOscDrive,
   input wire logic        clkOut,
   input wire logic [31:0] rtcCount
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic       wr;
   logic       mapped;
   logic       cntWr;
   logic [1:0] ctlFf;
   logic [2:0] selFf;
   logic [5:0] bdFf;
   logic [5:0] pipeFf;
   assign wr     = psel & penable & pwrite;
   assign mapped = paddr[31:5] == 27'h0 && paddr[4:0] <= 5'h10 && paddr[1:0] == 2'h0;
   assign cntWr  = wr && paddr == {27'h0, RTC_COUNT_OFF};
   // Shadows of the writable fields except the PLL reference bits and the count; only exact word addresses count
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctlFf <= 2'h0;
         selFf <= 3'h0;
         bdFf  <= 6'h0;
      end else if (wr) begin
         if (paddr == {27'h0, CLK_CTRL_OFF}) ctlFf <= pwdata[1:0];
         if (paddr == {27'h0, CLK_CFG_OFF}) selFf <= pwdata[2:0];
         if (paddr == {27'h0, BACKUP_CTRL_OFF}) bdFf <= pwdata[5:0];
      end
   end
   // Two-deep copy of the plain sources, same latency as the output path
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) pipeFf <= 6'h0;
      else pipeFf <= {pipeFf[2:0], internalRc48m, internalRc8m, systemClock};
   end
   a_ready_always: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
      else $error("slave error flag wrong for address");
   a_clkout_route: assert property (selFf inside {3'h0, 3'h1, 3'h6} && $stable(selFf)
      |-> clkOut == pipeFf[selFf[2] ? 5 : 3 + selFf[0]])
      else $error("clock output does not follow selected source");
   a_reserved_low: assert property (selFf == 3'h7 && $stable(selFf) |-> !clkOut)
      else $error("reserved select does not hold output low");
   a_fast_bypass: assert property (fastOscAmpEnable == (ctlFf == 2'h1))
      else $error("fast amplifier enable wrong");
   a_slow_bypass: assert property (slowOscAmpEnable == (bdFf[1:0] == 2'h1))
      else $error("slow amplifier enable wrong");
   a_drive_field: assert property (slowOscDrive == bdFf[3:2])
      else $error("slow drive output wrong");
   a_rtc_halt: assert property ((bdFf[5:4] == 2'h3 && !mainPowerGood && !cntWr) [*3]
      |-> $stable(rtcCount))
      else $error("counter moved without main power");
   a_rtc_step: assert property ($changed(rtcCount) && !$past(cntWr)
      |-> rtcCount == $past(rtcCount) + 32'h1)
      else $error("counter did not step by one");
   c_reserved: cover property (selFf == 3'h7 && $stable(selFf));
   c_halted: cover property (bdFf[5:4] == 2'h3 && !mainPowerGood);
   c_unmapped: cover property (psel && penable && pslverr);
endmodule // clock_select_asserts
bind clock_source_output_select clock_select_asserts checker_inst (.*);

// ===== testbench/clock_source_output_select_tb.sv
`timescale 1ns/1ps
module clock_source_output_select_tb;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [7:0]  r;
      logic        e;
      logic [3:0]  o;
      logic [3:0]  f;
   } row_t;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        mainPowerGood = 1'b1;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rtcCount, rdv, keep;
   logic [9:0]  srcClk, d1, d2;
   logic [1:0]  slowOscDrive;
   logic        pready, pslverr, errv, fastOscAmpEnable, slowOscAmpEnable, mainPllRef, clkOut;
   int          n_errors = 0;
   int          check_count = 0;
   // Address, write data, readback, error, output source, reference source
   // Source 14 means held low, output source 15 means not compared
   row_t rows [15] = '{
      '{8'h00, 32'hffff_fff1, 8'h01, 1'b0, 4'h0, 4'h7}, '{8'h04, 32'h2, 8'h02, 1'b0, 4'h7, 4'h7},
      '{8'h00, 32'h6, 8'h06, 1'b0, 4'h6, 4'h1}, '{8'h00, 32'hb, 8'h0b, 1'b0, 4'h6, 4'h2},
      '{8'h04, 32'h1, 8'h01, 1'b0, 4'h1, 4'h2}, '{8'h04, 32'h6, 8'h06, 1'b0, 4'h2, 4'h2},
      '{8'h08, 32'hd, 8'h0d, 1'b0, 4'h2, 4'h2}, '{8'h04, 32'h5, 8'h05, 1'b0, 4'h9, 4'h2},
      '{8'h08, 32'he, 8'h0e, 1'b0, 4'h8, 4'h2}, '{8'h04, 32'h7, 8'h07, 1'b0, 4'he, 4'h2},
      '{8'h04, 32'h3, 8'h03, 1'b0, 4'hf, 4'h2}, '{8'h04, 32'h4, 8'h04, 1'b0, 4'hf, 4'h2},
      '{8'h00, 32'hc, 8'h0c, 1'b0, 4'hf, 4'he}, '{8'h14, 32'hffff_ffff, 8'h00, 1'b1, 4'hf, 4'he},
      '{8'h10, 32'hffff_ffff, 8'h02, 1'b0, 4'hf, 4'he}};
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      d1 <= srcClk;
      d2 <= d1;
   end
   clock_sources_model partner (.clock(clock), .fastAmpEn(fastOscAmpEnable),
      .slowAmpEn(slowOscAmpEnable), .srcClk(srcClk));
   clock_source_output_select dut (.*, .systemClock(srcClk[0]), .internalRc8m(srcClk[1]),
      .internalRc48m(srcClk[2]), .internalRc40k(srcClk[3]), .mainPllClock(srcClk[4]),
      .secondPllClock(srcClk[5]), .fastOscInputPin(srcClk[6]), .fastOscAmpClock(srcClk[7]),
      .slowOscInputPin(srcClk[8]), .slowOscAmpClock(srcClk[9]));
   function automatic logic pick(input logic [3:0] o);
      return (o == 4'he) ? 1'b0 : d2[o];
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask
   // Held until pready is seen at an edge, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {24'h0, a};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         n_errors++;
         complete_run();
      end
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", 32'h0, rdv);
      end
      $display("reset test done");
   endtask
   initial begin
      do_reset();
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk("read data", {24'h0, rows[i].r}, rdv);
         chk("error flag", {31'h0, rows[i].e}, {31'h0, errv});
         repeat (8) begin
            @(negedge clock);
            if (rows[i].o != 4'hf) chk("clkOut", {31'h0, pick(rows[i].o)}, {31'h0, clkOut});
            chk("pll ref", {31'h0, pick(rows[i].f)}, {31'h0, mainPllRef});
         end
         @(posedge clock);
         $display("row %0d done", i);
      end
      chk("drive", 32'h3, {30'h0, slowOscDrive});
      apb(1'b1, 8'h08, 32'h31);
      apb(1'b1, 8'h0c, 32'hffff_fffe);
      repeat (40) @(posedge clock);
      apb(1'b0, 8'h0c, 32'h0);
      chk("count wraps", 32'h1, {31'h0, rdv < 32'h10});
      mainPowerGood <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1'b0, 8'h0c, 32'h0);
      keep = rdv;
      repeat (40) @(posedge clock);
      apb(1'b0, 8'h0c, 32'h0);
      chk("count held", keep, rdv);
      mainPowerGood <= 1'b1;
      repeat (40) @(posedge clock);
      apb(1'b0, 8'h0c, 32'h0);
      chk("count resumes", 32'h1, {31'h0, rdv > keep && rdv < keep + 32'h10});
      mainPowerGood <= 1'b0;
      apb(1'b1, 8'h08, 32'h21);
      keep = rdv;
      repeat (40) @(posedge clock);
      apb(1'b0, 8'h0c, 32'h0);
      chk("battery count", 32'h1, {31'h0, rdv != keep});
      $display("counter test done");
      do_reset();
      complete_run();
   end
endmodule // clock_source_output_select_tb
